// ===== led_pwm_divider.sv
// Free-running divider producing one 50% duty square wave.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module led_pwm_divider #(
   parameter int HALF_CYCLES = 1712
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Square wave, high during the sink phase.
   output logic wave_o
);
   logic [15:0] count_q;

   // Toggle the wave each half period so high and low times match.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_q <= 16'h0000;
         wave_o <= 1'b0;
      end else if (count_q == 16'(HALF_CYCLES - 1)) begin
         count_q <= 16'h0000;
         wave_o <= ~wave_o;
      end else begin
         count_q <= count_q + 16'h0001;
      end
   end
endmodule // led_pwm_divider
`default_nettype wire

// ===== led_pwm_map.svh
// Constants for the sleep-state LED PWM driver: timing counts and decode codes.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef LED_PWM_MAP_SVH
`define LED_PWM_MAP_SVH

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define PWM_FREQ_HZ 7300
`define PWM_HALF_CYCLES ((1000000000 / `CLK_PERIOD_NS) / (2 * `PWM_FREQ_HZ))
`define STARTUP_MS 7
`define STARTUP_CYCLES (`STARTUP_MS * (1000000 / `CLK_PERIOD_NS))

// ---------------------------------------------------------------------------
// Sleep input codes {suspend, soft_off, hibernate, standby}
// ---------------------------------------------------------------------------
`define CODE_AWAKE 4'hF
`define CODE_STANDBY 4'hE
`define CODE_HIBERNATE 4'hC
`define CODE_SOFT_OFF 4'h8
`define CODE_DSW_A 4'h0
`define CODE_DSW_B 4'h2

`endif

// ===== led_pwm_pkg.sv
// Types shared by the sleep-state LED PWM driver.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package led_pwm_pkg;
   typedef enum logic [2:0] {SEL_NONE, SEL_STANDBY, SEL_HIBERNATE, SEL_SOFT_OFF, SEL_DSW} led_sel_e;
endpackage
`default_nettype wire

// ===== sleep_led_partner.sv
// Model of the board around the LED pins: five LEDs, each pin with a pull-up resistor.
// Assumes the driver's open-drain split into data and sink enable per pin.
`timescale 1ns/1ns
`default_nettype none
module sleep_led_partner (
   // Driver side: data level and sink enable per pin.
   input wire logic [4:0] data_i,
   input wire logic [4:0] sink_i,
   // Resolved pin levels seen by the LEDs.
   output logic [4:0] pin_o
);
   // A released pin rises to the pull-up; a sunk pin shows the driven data.
   // Driving data high while sinking would show as a missing low phase.
   always_comb begin
      for (int k = 0; k < 5; k++) begin
         pin_o[k] = sink_i[k] ? data_i[k] : 1'b1;
      end
   end
endmodule // sleep_led_partner
`default_nettype wire

// ===== sleep_state_led_pwm_driver.sv
// Sleep-state LED PWM driver: decodes sleep inputs into five open-drain LED blinkers.
// Assumes inputs synchronous to CLK_I and external pull-ups on the LED pins.
// Behaviour
// - All four sleep inputs high floats the four sleep LEDs.
// - Only standby low blinks the standby LED alone.
// - Standby and hibernate low blinks the hibernate LED alone.
// - Standby, hibernate, soft-off low blinks the soft-off LED alone.
// - All four low blinks the deep-sleep-well LED alone.
// - All low except hibernate also blinks the deep-sleep-well LED.
// - Management LED blinks when its sleep input is high, else floats.
// - Active outputs carry a 50% square wave near 7.3 kHz.
// - All outputs float until power-up completes.
// - Decoding begins about 7 ms after reset release.
`timescale 1ns/1ns
`default_nettype none
`include "led_pwm_map.svh"
module sleep_state_led_pwm_driver
   import led_pwm_pkg::*;
#(
   parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
   parameter int HALF_CYCLES = `PWM_HALF_CYCLES
) (
   // Clock and reset.
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   // Sleep-state inputs, active low.
   input wire logic STANDBY_SLEEP_N_I,
   input wire logic HIBERNATE_SLEEP_N_I,
   input wire logic SOFT_OFF_SLEEP_N_I,
   input wire logic SUSPEND_WELL_SLEEP_N_I,
   input wire logic MGMT_ENGINE_SLEEP_N_I,
   // Open-drain LED pins: output level is always low, enable sinks the pin.
   output logic STANDBY_LED_OUT_O,
   output logic STANDBY_LED_OUT_OE_O,
   output logic HIBERNATE_LED_OUT_O,
   output logic HIBERNATE_LED_OUT_OE_O,
   output logic SOFT_OFF_LED_OUT_O,
   output logic SOFT_OFF_LED_OUT_OE_O,
   output logic DEEP_SLEEP_WELL_LED_OUT_O,
   output logic DEEP_SLEEP_WELL_LED_OUT_OE_O,
   output logic MGMT_ENGINE_LED_OUT_O,
   output logic MGMT_ENGINE_LED_OUT_OE_O
);

   // ------------------------------------------------------------------------
   // Decode function
   // ------------------------------------------------------------------------
   // Table decode of {suspend, soft-off, hibernate, standby}; anything unlisted floats.
   function automatic led_sel_e decode_sleep(input logic [3:0] code);
      led_sel_e pick;
      pick = SEL_NONE;
      if (code == `CODE_AWAKE) begin
         pick = SEL_NONE;
      end else if (code == `CODE_STANDBY) begin
         pick = SEL_STANDBY;
      end else if (code == `CODE_HIBERNATE) begin
         pick = SEL_HIBERNATE;
      end else if (code == `CODE_SOFT_OFF) begin
         pick = SEL_SOFT_OFF;
      end else if (code == `CODE_DSW_A || code == `CODE_DSW_B) begin
         pick = SEL_DSW;
      end else begin
         pick = SEL_NONE;
      end
      return pick;
   endfunction

   // ------------------------------------------------------------------------
   // Power-up hold
   // ------------------------------------------------------------------------
   logic [31:0] hold_q;
   logic ready_q;

   // Count out the start-up time; nothing drives until it expires.
   // The count stops once ready is set, so it cannot wrap in a long run.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         hold_q <= 32'h0000_0000;
         ready_q <= 1'b0;
      end else if (!ready_q) begin
         if (hold_q == 32'(STARTUP_CYCLES - 1)) begin
            ready_q <= 1'b1;
         end
         hold_q <= hold_q + 32'h0000_0001;
      end
   end

   // ------------------------------------------------------------------------
   // Shared PWM divider
   // ------------------------------------------------------------------------
   logic wave;

   // A single divider keeps every LED in phase and avoids per-pin drift.
   // The wave keeps running through the hold, so the first blink may start mid-phase.
   led_pwm_divider #(
      .HALF_CYCLES(HALF_CYCLES)
   ) u_div (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .wave_o(wave)
   );

   // ------------------------------------------------------------------------
   // Output enables
   // ------------------------------------------------------------------------
   led_sel_e sel;
   logic sink;
   logic [4:0] oe_q;

   // Decode the four sleep inputs; the management input bypasses the table.
   // The hold gate sits before the register, so no pin can blink early.
   assign sel = decode_sleep({SUSPEND_WELL_SLEEP_N_I, SOFT_OFF_SLEEP_N_I,
                              HIBERNATE_SLEEP_N_I, STANDBY_SLEEP_N_I});
   assign sink = wave & ready_q;

   // Registered enables so pins change glitch-free, one cycle after inputs.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         oe_q <= 5'h00;
      end else begin
         oe_q[0] <= sink && sel == SEL_STANDBY;
         oe_q[1] <= sink && sel == SEL_HIBERNATE;
         oe_q[2] <= sink && sel == SEL_SOFT_OFF;
         oe_q[3] <= sink && sel == SEL_DSW;
         oe_q[4] <= sink && MGMT_ENGINE_SLEEP_N_I;
      end
   end

   assign STANDBY_LED_OUT_OE_O = oe_q[0];
   assign HIBERNATE_LED_OUT_OE_O = oe_q[1];
   assign SOFT_OFF_LED_OUT_OE_O = oe_q[2];
   assign DEEP_SLEEP_WELL_LED_OUT_OE_O = oe_q[3];
   assign MGMT_ENGINE_LED_OUT_OE_O = oe_q[4];
   // Open drain only ever pulls low.
   assign STANDBY_LED_OUT_O = 1'b0;
   assign HIBERNATE_LED_OUT_O = 1'b0;
   assign SOFT_OFF_LED_OUT_O = 1'b0;
   assign DEEP_SLEEP_WELL_LED_OUT_O = 1'b0;
   assign MGMT_ENGINE_LED_OUT_O = 1'b0;

   // ------------------------------------------------------------------------
   // Assertion helpers
   // ------------------------------------------------------------------------
   logic wave_last_q;
   logic [15:0] run_q;

   // Count how long the wave has held its level, so one step checks a whole phase.
   // A repetition as long as a real half period would be impractical to check.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         wave_last_q <= 1'b0;
         run_q <= 16'h0000;
      end else begin
         wave_last_q <= wave;
         if (wave != wave_last_q) begin
            run_q <= 16'h0001;
         end else begin
            run_q <= run_q + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   // Decode checks that expect a blink are gated by sink, because a pin only ever sinks in the low phase.
   a_hold_floats: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !ready_q |-> ##1 (oe_q == 5'h00))
      else $error("Output driven before start-up ended.");
   a_idle_floats: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      ({SUSPEND_WELL_SLEEP_N_I, SOFT_OFF_SLEEP_N_I, HIBERNATE_SLEEP_N_I,
        STANDBY_SLEEP_N_I} == 4'hF) |=> (oe_q[3:0] == 4'h0))
      else $error("Sleep LED driven while awake.");
   a_standby_only: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (sel == SEL_STANDBY && sink) |=> (oe_q[3:0] == 4'h1))
      else $error("Standby decode wrong.");
   a_hibernate_only: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (sel == SEL_HIBERNATE && sink) |=> (oe_q[3:0] == 4'h2))
      else $error("Hibernate decode wrong.");
   a_soft_off_only: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (sel == SEL_SOFT_OFF && sink) |=> (oe_q[3:0] == 4'h4))
      else $error("Soft-off decode wrong.");
   a_dsw_all_low: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      ({SUSPEND_WELL_SLEEP_N_I, SOFT_OFF_SLEEP_N_I, HIBERNATE_SLEEP_N_I,
        STANDBY_SLEEP_N_I} == 4'h0 && sink) |=> (oe_q[3:0] == 4'h8))
      else $error("Deep-sleep-well decode wrong.");
   a_dsw_hib_high: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      ({SUSPEND_WELL_SLEEP_N_I, SOFT_OFF_SLEEP_N_I, HIBERNATE_SLEEP_N_I,
        STANDBY_SLEEP_N_I} == 4'h2 && sink) |=> (oe_q[3:0] == 4'h8))
      else $error("Deep-sleep-well alternate decode wrong.");
   a_mgmt_follows: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      sink |=> (oe_q[4] == $past(MGMT_ENGINE_SLEEP_N_I)))
      else $error("Management LED does not follow its input.");
   a_unlisted_float: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (sel == SEL_NONE) |=> (oe_q[3:0] == 4'h0))
      else $error("Sleep LED driven on unlisted code.");
   a_wave_half: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      $rose(wave) |=> wave [*3])
      else $error("PWM high phase too short.");

   // Phase and start-up checks lean on the helper counters above.
   a_wave_period: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (wave != wave_last_q) |-> (run_q == 16'(HALF_CYCLES)))
      else $error("PWM phase length differs from the half period.");
   a_sink_low_phase: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      (oe_q != 5'h00) |-> $past(wave))
      else $error("Sink enabled outside the low phase.");
   a_data_low: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      {STANDBY_LED_OUT_O, HIBERNATE_LED_OUT_O, SOFT_OFF_LED_OUT_O,
       DEEP_SLEEP_WELL_LED_OUT_O, MGMT_ENGINE_LED_OUT_O} == 5'h00)
      else $error("Open-drain data level is not low.");
   a_ready_sticky: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      ready_q |=> ready_q)
      else $error("Start-up hold entered again without reset.");
   a_ready_time: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      $rose(ready_q) |-> (hold_q == 32'(STARTUP_CYCLES)))
      else $error("Start-up hold ended at the wrong count.");
   a_mgmt_floats: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
      !MGMT_ENGINE_SLEEP_N_I |=> !oe_q[4])
      else $error("Management LED sinks while its input is low.");
endmodule // sleep_state_led_pwm_driver
`default_nettype wire

// ===== sleep_state_led_pwm_driver_tb_top.sv
// Testbench for the sleep-state LED driver: start-up hold and full decode sweep.
// Assumes the pull-up model on all five pins and short timing parameters.
`timescale 1ns/1ns
`default_nettype none
module sleep_state_led_pwm_driver_tb_top;
   // -------------------------------------------------------------------------
   // Stimulus and observation
   // -------------------------------------------------------------------------
   localparam int SC = 20;
   localparam int HC = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] code = 4'hF; // Order is suspend, soft-off, hibernate, standby.
   logic mgmt = 1'b0;
   logic [4:0] oe;
   logic [4:0] dat;
   logic [4:0] pin;
   int miscompares = 0;
   int num_checks = 0;
   // The clock inverts every 20 ns, half of its 40 ns period.
   always #20 clk = ~clk;
   sleep_state_led_pwm_driver #(.STARTUP_CYCLES(SC), .HALF_CYCLES(HC)) u_dut (
      .CLK_I(clk), .SYS_RST_I(rst),
      .STANDBY_SLEEP_N_I(code[0]), .HIBERNATE_SLEEP_N_I(code[1]),
      .SOFT_OFF_SLEEP_N_I(code[2]), .SUSPEND_WELL_SLEEP_N_I(code[3]),
      .MGMT_ENGINE_SLEEP_N_I(mgmt),
      .STANDBY_LED_OUT_O(dat[0]), .STANDBY_LED_OUT_OE_O(oe[0]),
      .HIBERNATE_LED_OUT_O(dat[1]), .HIBERNATE_LED_OUT_OE_O(oe[1]),
      .SOFT_OFF_LED_OUT_O(dat[2]), .SOFT_OFF_LED_OUT_OE_O(oe[2]),
      .DEEP_SLEEP_WELL_LED_OUT_O(dat[3]), .DEEP_SLEEP_WELL_LED_OUT_OE_O(oe[3]),
      .MGMT_ENGINE_LED_OUT_O(dat[4]), .MGMT_ENGINE_LED_OUT_OE_O(oe[4]));
   sleep_led_partner u_leds (.data_i(dat), .sink_i(oe), .pin_o(pin));
   // -------------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Expected blinking sleep LEDs per code, bits dsw, soft-off, hibernate, standby.
   function automatic logic [3:0] mask_of(input logic [3:0] c);
      case (c)
         4'hE: return 4'h1;
         4'hC: return 4'h2;
         4'h8: return 4'h4;
         4'h0: return 4'h8;
         4'h2: return 4'h8;
         default: return 4'h0;
      endcase
   endfunction
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   // Reset, then the hold: a lit-up code must not blink before start-up ends.
   task automatic t_startup;
      int n;
      logic [4:0] rel;
      @(posedge clk);
      code <= 4'hE;
      mgmt <= 1'b1;
      rst <= 1'b1;
      @(posedge clk);
      rel = 5'h00;
      for (n = 0; n < 8 + SC - 1; n++) begin
         @(posedge clk);
         if (n == 7) rst <= 1'b0;
         #1 rel = rel | ~pin;
      end
      chk({3'h0, rel}, 8'h00);
      n = 0;
      while (pin[0] !== 1'b0 && n < 2 * HC + 4) begin
         @(posedge clk);
         #1 n++;
      end
      chk({7'h00, pin[0]}, 8'h00);
      $display("startup test done");
   endtask
   // Every sleep code with both management levels; one full period is counted.
   // A 50% wave of period 2*HC is low in exactly HC cycles of any such window.
   task automatic t_decode;
      int cnt[5];
      logic [3:0] m;
      for (int i = 0; i < 32; i++) begin
         @(posedge clk);
         code <= i[3:0];
         mgmt <= i[4];
         m = mask_of(i[3:0]);
         repeat (3) @(posedge clk);
         cnt = '{0, 0, 0, 0, 0};
         for (int k = 0; k < 2 * HC; k++) begin
            @(posedge clk);
            #1 for (int j = 0; j < 5; j++) if (pin[j] === 1'b0) cnt[j]++;
         end
         for (int j = 0; j < 4; j++) chk(8'(cnt[j]), m[j] ? 8'(HC) : 8'h00);
         chk(8'(cnt[4]), i[4] ? 8'(HC) : 8'h00);
      end
      $display("decode test done");
   endtask
   initial begin
      t_startup();
      t_decode();
      t_startup();
      wrap_up();
   end
   // The tests take under 800 cycles; a hang is cut off well beyond that.
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      $display("watchdog expired");
      wrap_up();
   end
endmodule // sleep_state_led_pwm_driver_tb_top
`default_nettype wire
